// ### include/seg_scan_pkg.sv
package seg_scan_pkg;
    // Clock and scan time base
    localparam int CLK_PERIOD_NS = 10;
    localparam int SCAN_TIME_NS = 1000;
    localparam int SCAN_CYCLES = (SCAN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Pass layout
    localparam logic [3:0] PASS_LAST_STEP = 4'hb;
    localparam logic [3:0] STEPS_PER_DIGIT = 4'h3;
    localparam logic [1:0] STROBE_PHASE = 2'h1;
    localparam logic [15:0] MAX_VALUE = 16'h270f;
    localparam logic [3:0] MAX_SETTING = 4'h7;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_SRC0 = 8'h04;
    localparam logic [7:0] OFS_SRC1 = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0c;
    localparam logic [7:0] OFS_MASK = 8'h10;
    localparam logic [7:0] OFS_ERRCODE = 8'h14;
    localparam logic [7:0] OFS_WORK = 8'h18;
    // Field positions
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_SET_LSB = 4;
    localparam int ST_DONE_BIT = 0;
    localparam int ST_OPERR_BIT = 1;
    localparam int ST_RANGE_BIT = 2;
    localparam int SET_TWO_BIT = 2;
    localparam int SET_DNEG_BIT = 1;
    localparam int SET_LNEG_BIT = 0;
    // Reset values and error codes
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [2:0] MASK_RESET = 3'h0;
    localparam logic [15:0] ERR_NONE = 16'h0000;
    localparam logic [15:0] ERR_RANGE = 16'h200b;
    localparam logic [15:0] ERR_OPER = 16'h2003;

    typedef struct packed {
        logic two;
        logic data_neg;
        logic strobe_neg;
    } cfg_t;

    typedef enum logic {
        PASS_IDLE,
        PASS_RUN
    } pass_state_t;
endpackage

// ### hw/latched_segment_display_op.sv
// Functional notes
// (RULE1) One display uses eight outputs; two displays use twelve outputs.
// (RULE2) First source word goes to display one, next word to display two.
// (RULE3) Each binary source value is converted to BCD before display.
// (RULE4) Setting 0..7; 0..3 is one display, 4..7 is two displays.
// (RULE5) Even settings positive strobes, odd negative; upper pair negative data.
// (RULE6) Positive data outputs equal BCD bits; negative data outputs are complemented.
// (RULE7) Active strobe is 1 in positive logic, 0 in negative logic.
// (RULE8) BCD data on outputs 0..3, digit strobes on outputs 4..7.
// (RULE9) Second display data on outputs 8..11, sharing the same strobes.
// (RULE10) Strobes step cyclically while enabled; one pass takes twelve scan cycles.
// (RULE11) Enable rising restarts the strobe sequence from its first step.
// (RULE12) Completion flag stands for exactly one scan cycle after each pass.
// (RULE13) A source value above 9999 raises an operation error.
// (RULE14) Software must not alter the reserved working word while in use.
// (RULE15) Setting outside 0..7: do not run, flag error, report range code.
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module latched_segment_display_op (
    input wire logic CLK_IN,
    input wire logic RST_N_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [7:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    output logic [11:0] SEG_OUT,
    output logic DISPLAY_PASS_DONE_FLAG_OUT,
    output logic ERR_OUT,
    output logic IRQ_OUT
);
    logic [31:0] ctrl_reg;
    logic [15:0] source_value_word0_reg;
    logic [15:0] source_value_word1_reg;
    logic [2:0] status_reg;
    logic [2:0] mask_reg;
    logic [15:0] errcode_reg;
    logic [3:0] step_reg;
    logic [6:0] tick_cnt_reg;
    logic tick;
    logic en_q_reg;
    logic en;
    logic en_rise;
    logic [3:0] setting;
    logic pass_start;
    logic pass_end;
    logic pass_ok_reg;
    seg_scan_pkg::pass_state_t state_reg;
    seg_scan_pkg::cfg_t cfg_reg;
    logic [15:0] bcd0_reg;
    logic [15:0] bcd1_reg;
    logic range_bad;
    logic value_bad;
    logic wr_fire;
    logic rd_fire;
    logic mapped;
    logic [31:0] rd_mux;
    logic [11:0] seg_next;
    logic [6:0] done_len;

    // Binary to BCD by shift and add-three, four digits wide
    function automatic logic [15:0] to_bcd(input logic [15:0] bin);
        logic [31:0] sh;
        sh = {16'h0000, bin};
        for (int i = 0; i < 16; i++) begin
            for (int d = 0; d < 4; d++) begin
                if (sh[16 + 4 * d +: 4] > 4'h4) begin
                    sh[16 + 4 * d +: 4] = sh[16 + 4 * d +: 4] + 4'h3;
                end
            end
            sh = {sh[30:0], 1'b0};
        end
        return sh[31:16];
    endfunction

    // Which digit place a pass step belongs to
    function automatic logic [1:0] digit_of(input logic [3:0] step);
        if (step < seg_scan_pkg::STEPS_PER_DIGIT) begin
            return 2'h0;
        end else if (step < 2 * seg_scan_pkg::STEPS_PER_DIGIT) begin
            return 2'h1;
        end else if (step < 3 * seg_scan_pkg::STEPS_PER_DIGIT) begin
            return 2'h2;
        end
        return 2'h3;
    endfunction

    // Decode of the setting and the source words
    assign en = ctrl_reg[seg_scan_pkg::CTRL_EN_BIT];
    assign setting = ctrl_reg[seg_scan_pkg::CTRL_SET_LSB +: 4];
    assign en_rise = en & ~en_q_reg;
    assign range_bad = setting > seg_scan_pkg::MAX_SETTING;
    assign value_bad = (source_value_word0_reg > seg_scan_pkg::MAX_VALUE)
        | (setting[seg_scan_pkg::SET_TWO_BIT]
        & (source_value_word1_reg > seg_scan_pkg::MAX_VALUE));
    assign tick = tick_cnt_reg == 7'(seg_scan_pkg::SCAN_CYCLES - 1);
    assign pass_end = tick & (step_reg == seg_scan_pkg::PASS_LAST_STEP);
    assign pass_start = en_rise | (en & pass_end);

    // APB strobes: a write lands only at the edge where the ready flop is high
    assign wr_fire = PSEL_IN & PENABLE_IN & PREADY_OUT & PWRITE_IN;
    assign rd_fire = PSEL_IN & PENABLE_IN & ~PREADY_OUT & ~PWRITE_IN;

    // Read multiplexer; unmapped addresses read zero and report slave error
    always_comb begin
        rd_mux = 32'h0000_0000;
        mapped = 1'b1;
        unique case (PADDR_IN)
            seg_scan_pkg::OFS_CTRL: rd_mux = ctrl_reg;
            seg_scan_pkg::OFS_SRC0: rd_mux = {16'h0000, source_value_word0_reg};
            seg_scan_pkg::OFS_SRC1: rd_mux = {16'h0000, source_value_word1_reg};
            seg_scan_pkg::OFS_STATUS: rd_mux = {29'h0000_0000, status_reg};
            seg_scan_pkg::OFS_MASK: rd_mux = {29'h0000_0000, mask_reg};
            seg_scan_pkg::OFS_ERRCODE: rd_mux = {16'h0000, errcode_reg};
            seg_scan_pkg::OFS_WORK: rd_mux = {23'h00_0000, pass_ok_reg, state_reg,
                3'h0, step_reg};
            default: mapped = 1'b0;
        endcase
    end

    // One wait state keeps ready and read data straight from flops
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            PREADY_OUT <= 1'b0;
            PSLVERR_OUT <= 1'b0;
            PRDATA_OUT <= 32'h0000_0000;
        end else begin
            PREADY_OUT <= PSEL_IN & PENABLE_IN & ~PREADY_OUT;
            PSLVERR_OUT <= PSEL_IN & PENABLE_IN & ~PREADY_OUT & ~mapped;
            if (rd_fire) begin
                PRDATA_OUT <= rd_mux;
            end
        end
    end

    // Software-written control and source words
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            ctrl_reg <= seg_scan_pkg::CTRL_RESET;
            source_value_word0_reg <= 16'h0000;
            source_value_word1_reg <= 16'h0000;
            mask_reg <= seg_scan_pkg::MASK_RESET;
        end else if (wr_fire) begin
            unique case (PADDR_IN)
                seg_scan_pkg::OFS_CTRL: ctrl_reg <= {24'h00_0000, PWDATA_IN[7:0]};
                seg_scan_pkg::OFS_SRC0: source_value_word0_reg <= PWDATA_IN[15:0];
                seg_scan_pkg::OFS_SRC1: source_value_word1_reg <= PWDATA_IN[15:0];
                seg_scan_pkg::OFS_MASK: mask_reg <= PWDATA_IN[2:0];
                // Working word is read-only, so software cannot disturb a pass
                default: ; // see (RULE14)
            endcase
        end
    end

    // Scan cycle time base, realigned on enable rising
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            tick_cnt_reg <= 7'h00;
            en_q_reg <= 1'b0;
        end else begin
            en_q_reg <= en;
            if (!en || en_rise || tick) begin
                tick_cnt_reg <= 7'h00;
            end else begin
                tick_cnt_reg <= tick_cnt_reg + 7'h01;
            end
        end
    end

    // Pass sequencer; settings and values are frozen per pass to avoid torn digits
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            state_reg <= seg_scan_pkg::PASS_IDLE;
            step_reg <= 4'h0;
            pass_ok_reg <= 1'b0;
            cfg_reg <= '0;
            bcd0_reg <= 16'h0000;
            bcd1_reg <= 16'h0000;
        end else if (!en) begin
            state_reg <= seg_scan_pkg::PASS_IDLE;
            step_reg <= 4'h0;
            pass_ok_reg <= 1'b0;
        end else if (pass_start) begin
            state_reg <= seg_scan_pkg::PASS_RUN;
            step_reg <= 4'h0; // see (RULE10) (RULE11)
            pass_ok_reg <= ~range_bad & ~value_bad; // see (RULE13) (RULE15)
            cfg_reg.two <= setting[seg_scan_pkg::SET_TWO_BIT]; // see (RULE4)
            cfg_reg.data_neg <= setting[seg_scan_pkg::SET_DNEG_BIT]; // see (RULE5)
            cfg_reg.strobe_neg <= setting[seg_scan_pkg::SET_LNEG_BIT]; // see (RULE5)
            bcd0_reg <= to_bcd(source_value_word0_reg); // see (RULE2) (RULE3)
            bcd1_reg <= to_bcd(source_value_word1_reg); // see (RULE2) (RULE3)
        end else if (tick) begin
            step_reg <= step_reg + 4'h1; // see (RULE10)
        end
    end

    // Output pattern: data set up, strobe for one scan cycle, then data held
    always_comb begin
        logic [1:0] dig;
        logic [1:0] phase;
        logic [3:0] nib0;
        logic [3:0] nib1;
        logic [3:0] strobes;
        dig = digit_of(step_reg);
        phase = 2'(step_reg - 4'(dig) * seg_scan_pkg::STEPS_PER_DIGIT);
        nib0 = bcd0_reg[4 * dig +: 4];
        nib1 = bcd1_reg[4 * dig +: 4];
        strobes = 4'h0;
        if (phase == seg_scan_pkg::STROBE_PHASE) begin
            strobes[dig] = 1'b1;
        end
        seg_next = {4'h0, {4{cfg_reg.strobe_neg}}, 4'h0};
        if (state_reg == seg_scan_pkg::PASS_RUN && pass_ok_reg) begin
            seg_next[3:0] = cfg_reg.data_neg ? ~nib0 : nib0; // see (RULE6) (RULE8)
            seg_next[7:4] = cfg_reg.strobe_neg ? ~strobes : strobes; // see (RULE7) (RULE8)
            if (cfg_reg.two) begin
                seg_next[11:8] = cfg_reg.data_neg ? ~nib1 : nib1; // see (RULE9)
            end
        end
        // Upper nibble stays low with one display: only eight outputs occupied
        seg_next[11:8] = cfg_reg.two ? seg_next[11:8] : 4'h0; // see (RULE1)
    end

    // Output flops
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            SEG_OUT <= 12'h000;
        end else begin
            SEG_OUT <= seg_next;
        end
    end

    // Completion flag is held for exactly one scan cycle after a clean pass
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            DISPLAY_PASS_DONE_FLAG_OUT <= 1'b0;
        end else if (!en || en_rise) begin
            DISPLAY_PASS_DONE_FLAG_OUT <= 1'b0;
        end else if (tick) begin
            DISPLAY_PASS_DONE_FLAG_OUT <= pass_end & pass_ok_reg; // see (RULE12)
        end
    end

    // Sticky status; a new event wins over a same-cycle write-one clear
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            status_reg <= 3'h0;
            errcode_reg <= seg_scan_pkg::ERR_NONE;
        end else begin
            logic [2:0] set_v;
            logic [2:0] clr_v;
            set_v = 3'h0;
            set_v[seg_scan_pkg::ST_DONE_BIT] = en & pass_end & pass_ok_reg;
            set_v[seg_scan_pkg::ST_OPERR_BIT] = en & ~range_bad & value_bad; // see (RULE13)
            set_v[seg_scan_pkg::ST_RANGE_BIT] = en & range_bad; // see (RULE15)
            clr_v = (wr_fire && PADDR_IN == seg_scan_pkg::OFS_STATUS) ? PWDATA_IN[2:0] : 3'h0;
            status_reg <= (status_reg & ~clr_v) | set_v;
            if (set_v[seg_scan_pkg::ST_RANGE_BIT]) begin
                errcode_reg <= seg_scan_pkg::ERR_RANGE; // see (RULE15)
            end else if (set_v[seg_scan_pkg::ST_OPERR_BIT]) begin
                errcode_reg <= seg_scan_pkg::ERR_OPER;
            end
        end
    end

    // Interrupt and error levels
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            IRQ_OUT <= 1'b0;
            ERR_OUT <= 1'b0;
        end else begin
            IRQ_OUT <= |(status_reg & mask_reg);
            ERR_OUT <= status_reg[seg_scan_pkg::ST_OPERR_BIT]
                | status_reg[seg_scan_pkg::ST_RANGE_BIT]; // see (RULE13) (RULE15)
        end
    end

    // Helper: length of the current completion flag
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            done_len <= 7'h00;
        end else if (DISPLAY_PASS_DONE_FLAG_OUT) begin
            done_len <= done_len + 7'h01;
        end else begin
            done_len <= 7'h00;
        end
    end

    a_step_bound: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // see (RULE10)
        step_reg <= seg_scan_pkg::PASS_LAST_STEP)
        else $error("pass step ran past the last step");

    a_enable_restart: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // see (RULE11)
        en_rise |=> (step_reg == 4'h0 && state_reg == seg_scan_pkg::PASS_RUN
        && tick_cnt_reg == 7'h00))
        else $error("enable rise did not restart the pass");

    a_done_length: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // see (RULE12)
        $fell(DISPLAY_PASS_DONE_FLAG_OUT) && $past(en) && en
        |-> $past(done_len) == 7'(seg_scan_pkg::SCAN_CYCLES - 1))
        else $error("completion flag did not last one scan cycle");

    a_range_error: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // see (RULE15)
        en && range_bad |=> status_reg[seg_scan_pkg::ST_RANGE_BIT]
        && errcode_reg == seg_scan_pkg::ERR_RANGE ##1 ERR_OUT)
        else $error("bad setting not reported");

    a_strobe_single: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // see (RULE7)
        $countones($past(cfg_reg.strobe_neg) ? ~SEG_OUT[7:4] : SEG_OUT[7:4]) <= 1)
        else $error("more than one digit strobe active");

    a_one_display: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // see (RULE1)
        !$past(cfg_reg.two) |-> SEG_OUT[11:8] == 4'h0)
        else $error("upper outputs driven with one display");

    a_no_run_fault: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // see (RULE13)
        pass_start && value_bad ##1 !pass_start [*2]
        |-> SEG_OUT[7:4] == {4{$past(cfg_reg.strobe_neg)}})
        else $error("strobes active during a faulted pass");

    a_irq_level: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        (|(status_reg & mask_reg)) |=> IRQ_OUT)
        else $error("interrupt missing for unmasked status");

    a_ready_pulse: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        PSEL_IN && PENABLE_IN && !PREADY_OUT |=> PREADY_OUT ##1 !PREADY_OUT)
        else $error("ready not a single-cycle answer");

    a_done_at_end: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // see (RULE12)
        $rose(DISPLAY_PASS_DONE_FLAG_OUT) |-> $past(pass_end) && $past(pass_ok_reg))
        else $error("completion flag raised without a clean pass");

    a_err_level: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // see (RULE13)
        status_reg[seg_scan_pkg::ST_OPERR_BIT] || status_reg[seg_scan_pkg::ST_RANGE_BIT]
        |=> ERR_OUT)
        else $error("error pin low while an error is recorded");

    // Disabled: data lines fall two clocks later, once the idle state reaches the flops
    a_idle_dark: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        !en |-> ##2 (SEG_OUT[3:0] == 4'h0 && SEG_OUT[11:8] == 4'h0))
        else $error("data lines driven while disabled");
endmodule
`default_nettype wire

// ### test/seg_display_model.sv
`timescale 1ns/1ps
`default_nettype none
// Two four-place latched digit drivers on shared strobes. A place latch is
// transparent while its strobe sits at the active level, so it keeps the last
// nibble seen before the strobe drops; garbage between passes is overwritten.
module seg_display_model (
    input wire logic clk_in,
    input wire logic [11:0] seg_in,
    input wire logic strobe_neg_in,
    input wire logic data_neg_in,
    output logic [15:0] disp1_out,
    output logic [15:0] disp2_out
);
    // Place p follows strobe line 4+p and holds the decoded BCD nibble
    always_ff @(posedge clk_in) begin
        for (int p = 0; p < 4; p++) begin
            if (seg_in[4 + p] == !strobe_neg_in) begin
                disp1_out[p*4 +: 4] <= seg_in[3:0] ^ {4{data_neg_in}};
                disp2_out[p*4 +: 4] <= seg_in[11:8] ^ {4{data_neg_in}};
            end
        end
    end
endmodule
`default_nettype wire

// ### test/latched_segment_display_op_tb.sv
`timescale 1ns/1ps
`default_nettype none
module latched_segment_display_op_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, done, err, irq, e;
    logic lneg = 1'b0;
    logic dneg = 1'b0;
    logic [11:0] seg;
    logic [15:0] shown1, shown2, v0, v1, want2;
    int num_errors = 0;
    int check_count = 0;
    int seed = 19112;
    int n;

    latched_segment_display_op dut (.CLK_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel),
        .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
        .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .SEG_OUT(seg),
        .DISPLAY_PASS_DONE_FLAG_OUT(done), .ERR_OUT(err), .IRQ_OUT(irq));
    seg_display_model panel (.clk_in(clk), .seg_in(seg), .strobe_neg_in(lneg),
        .data_neg_in(dneg), .disp1_out(shown1), .disp2_out(shown2));

    // 100 MHz system clock
    initial begin
        forever #5 clk = ~clk;
    end

    // Verdict and end of run
    task automatic end_sim;
        if (num_errors == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string what);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %s got %b want %b", $time, what, got, exp);
        end
    endtask

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin
            num_errors++;
            $display("wrong value at %0t: bus answer never came", $time);
            end_sim();
        end
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Bounded wait for the pass flag; a required flag that never shows ends the run
    task automatic wait_done(input int lim, input bit must, output int cyc);
        cyc = 0;
        while (done !== 1'b1 && cyc < lim) begin
            @(posedge clk);
            cyc++;
        end
        if (must && done !== 1'b1) begin
            num_errors++;
            $display("wrong value at %0t: pass flag never came", $time);
            end_sim();
        end
    endtask

    // Expected packed BCD, units in the low nibble
    function automatic logic [15:0] to_bcd(input logic [15:0] v);
        int x;
        x = v;
        to_bcd = 16'h0000;
        for (int d = 0; d < 4; d++) begin
            to_bcd[d*4 +: 4] = 4'(x % 10);
            x = x / 10;
        end
    endfunction

    // Main sequence; the reserved work word is never written
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b0, seg_scan_pkg::OFS_CTRL, 32'h0);
        chk_word(rd, seg_scan_pkg::CTRL_RESET, "ctrl reset");
        apb(1'b0, seg_scan_pkg::OFS_MASK, 32'h0);
        chk_word(rd, {29'h0, seg_scan_pkg::MASK_RESET}, "mask reset");
        apb(1'b0, 8'h40, 32'h0);
        chk_bit(e, 1'b1, "unmapped error");
        apb(1'b1, seg_scan_pkg::OFS_MASK, 32'h1);
        // Every setting, random values with 9999 and 0 as corner cases
        for (int s = 0; s < 8; s++) begin
            v0 = (s == 0) ? 16'h270f : 16'($unsigned($random(seed)) % 10000);
            v1 = (s == 7) ? 16'h0000 : 16'($unsigned($random(seed)) % 10000);
            lneg <= s[seg_scan_pkg::SET_LNEG_BIT];
            dneg <= s[seg_scan_pkg::SET_DNEG_BIT];
            apb(1'b1, seg_scan_pkg::OFS_CTRL, 32'h0);
            apb(1'b1, seg_scan_pkg::OFS_SRC0, {16'h0, v0});
            apb(1'b1, seg_scan_pkg::OFS_SRC1, {16'h0, v1});
            apb(1'b1, seg_scan_pkg::OFS_CTRL, 32'((s << seg_scan_pkg::CTRL_SET_LSB) | 1));
            wait_done(1400, 1'b1, n);
            n = 0;
            while (done === 1'b1 && n < 200) begin
                @(posedge clk);
                n++;
            end
            // One display leaves the upper lines low, which the panel decodes as all ones when data is negative
            want2 = (s > 3) ? to_bcd(v1) : {4{dneg, dneg, dneg, dneg}};
            chk_word(n, seg_scan_pkg::SCAN_CYCLES, "flag width");
            chk_word(shown1, to_bcd(v0), "display one");
            chk_word(shown2, want2, "display two");
            if (s == 0) begin
                chk_bit(irq, 1'b1, "irq raised");
                apb(1'b0, seg_scan_pkg::OFS_STATUS, 32'h0);
                chk_bit(rd[seg_scan_pkg::ST_DONE_BIT], 1'b1, "done status");
                apb(1'b1, seg_scan_pkg::OFS_STATUS, 32'h1);
                apb(1'b1, seg_scan_pkg::OFS_MASK, 32'h0);
                chk_bit(irq, 1'b0, "irq cleared");
            end
        end
        chk_bit(irq, 1'b0, "irq masked");
        // Enable dropped and raised mid-pass restarts the full twelve steps
        lneg <= 1'b0;
        dneg <= 1'b0;
        apb(1'b1, seg_scan_pkg::OFS_CTRL, 32'h0);
        apb(1'b1, seg_scan_pkg::OFS_CTRL, 32'h1);
        repeat (600) @(posedge clk);
        apb(1'b1, seg_scan_pkg::OFS_CTRL, 32'h0);
        apb(1'b1, seg_scan_pkg::OFS_CTRL, 32'h1);
        wait_done(1400, 1'b1, n);
        chk_bit(n >= 1195 && n <= 1210, 1'b1, "restart timing");
        // Second word above 9999 on two displays
        apb(1'b1, seg_scan_pkg::OFS_CTRL, 32'h0);
        apb(1'b1, seg_scan_pkg::OFS_SRC0, 32'h64);
        apb(1'b1, seg_scan_pkg::OFS_SRC1, 32'h2710);
        apb(1'b1, seg_scan_pkg::OFS_CTRL, 32'h41);
        repeat (20) @(posedge clk);
        chk_bit(err, 1'b1, "op error pin");
        apb(1'b0, seg_scan_pkg::OFS_STATUS, 32'h0);
        chk_bit(rd[seg_scan_pkg::ST_OPERR_BIT], 1'b1, "op error bit");
        apb(1'b0, seg_scan_pkg::OFS_ERRCODE, 32'h0);
        chk_word(rd, {16'h0, seg_scan_pkg::ERR_OPER}, "op error code");
        wait_done(1300, 1'b0, n);
        chk_bit(done, 1'b0, "no pass on bad value");
        apb(1'b1, seg_scan_pkg::OFS_CTRL, 32'h0);
        apb(1'b1, seg_scan_pkg::OFS_STATUS, 32'h6);
        // Error pin follows the status word through one more flop
        repeat (2) @(posedge clk);
        chk_bit(err, 1'b0, "error cleared");
        // Setting 8 is out of range
        apb(1'b1, seg_scan_pkg::OFS_CTRL, 32'h81);
        repeat (20) @(posedge clk);
        chk_bit(err, 1'b1, "range error pin");
        apb(1'b0, seg_scan_pkg::OFS_STATUS, 32'h0);
        chk_bit(rd[seg_scan_pkg::ST_RANGE_BIT], 1'b1, "range error bit");
        apb(1'b1, seg_scan_pkg::OFS_ERRCODE, 32'h0);
        apb(1'b0, seg_scan_pkg::OFS_ERRCODE, 32'h0);
        chk_word(rd, {16'h0, seg_scan_pkg::ERR_RANGE}, "range error code");
        wait_done(1300, 1'b0, n);
        chk_bit(done, 1'b0, "no pass on bad setting");
        end_sim();
    end
endmodule
`default_nettype wire
